// ==== capture_window.sv ====
// Frame timing and capture window with Wishbone register access
//
// Implementation choices: the placing of the registers and the Wishbone register port.
`include "capture_cfg.svh"
`default_nettype none
module capture_window #(
  parameter int DW = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic pix_clk_i,
  input wire logic [DW-1:0] pix_data_i,
  input wire logic line_sync_i,
  input wire logic frame_sync_i,
  input wire logic field_id_i,
  output logic line_sync_o,
  output logic line_sync_oe_o,
  output logic frame_sync_o,
  output logic frame_sync_oe_o,
  output logic mem_wr_o,
  output logic [DW-1:0] mem_data_o
);

  // ==========================================================
  // System side registers
  logic dir_r, dir_nxt;
  logic [15:0] plen_r, plen_nxt, hlpf_r, hlpf_nxt;
  logic [14:0] spix_r, spix_nxt, npix_r, npix_nxt;
  logic [14:0] sl0_r, sl0_nxt, sl1_r, sl1_nxt, nlin_r, nlin_nxt;
  logic ack_r, ack_nxt;
  logic [31:0] dat_r, dat_nxt;
  logic req_tgl_r, req_tgl_nxt;
  logic ack_tgl_s;
  logic [1:0] stat_s;
  logic busy;
  logic take;

  function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0] sel);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        m[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return m;
  endfunction

  assign busy = req_tgl_r != ack_tgl_s;
  // Writes wait while a copy to the pixel side is in flight
  assign take = wb_cyc_i && wb_stb_i && !ack_r && !(wb_we_i && busy);

  always_comb begin
    logic [31:0] w;
    w = '0;
    dir_nxt = dir_r;
    plen_nxt = plen_r;
    hlpf_nxt = hlpf_r;
    spix_nxt = spix_r;
    npix_nxt = npix_r;
    sl0_nxt = sl0_r;
    sl1_nxt = sl1_r;
    nlin_nxt = nlin_r;
    req_tgl_nxt = req_tgl_r;
    ack_nxt = take;
    dat_nxt = '0;
    unique case (wb_adr_i)
      `OFS_MODE: w = {31'h0, dir_r};
      `OFS_PLEN: w = {16'h0, plen_r};
      `OFS_HLPF: w = {16'h0, hlpf_r};
      `OFS_SPIX: w = {17'h0, spix_r};
      `OFS_NPIX: w = {17'h0, npix_r};
      `OFS_SL0: w = {17'h0, sl0_r};
      `OFS_SL1: w = {17'h0, sl1_r};
      `OFS_NLIN: w = {17'h0, nlin_r};
      `OFS_STAT: w = {30'h0, stat_s};
      default: w = '0;
    endcase
    if (take && !wb_we_i) begin
      dat_nxt = w;
    end
    if (take && wb_we_i) begin
      w = lane_merge(w, wb_dat_i, wb_sel_i);
      req_tgl_nxt = !req_tgl_r;
      unique case (wb_adr_i)
        `OFS_MODE: dir_nxt = w[`MODE_DIR_BIT];
        `OFS_PLEN: plen_nxt = w[15:0];
        `OFS_HLPF: hlpf_nxt = w[15:0];
        `OFS_SPIX: spix_nxt = w[14:0];
        `OFS_NPIX: npix_nxt = w[14:0];
        `OFS_SL0: sl0_nxt = w[14:0];
        `OFS_SL1: sl1_nxt = w[14:0];
        `OFS_NLIN: nlin_nxt = w[14:0];
        default: req_tgl_nxt = req_tgl_r;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dir_r <= 1'b0;
      plen_r <= `REG_RESET;
      hlpf_r <= `REG_RESET;
      spix_r <= 15'h0000;
      npix_r <= 15'h0000;
      sl0_r <= 15'h0000;
      sl1_r <= 15'h0000;
      nlin_r <= 15'h0000;
      req_tgl_r <= 1'b0;
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end else begin
      dir_r <= dir_nxt;
      plen_r <= plen_nxt;
      hlpf_r <= hlpf_nxt;
      spix_r <= spix_nxt;
      npix_r <= npix_nxt;
      sl0_r <= sl0_nxt;
      sl1_r <= sl1_nxt;
      nlin_r <= nlin_nxt;
      req_tgl_r <= req_tgl_nxt;
      ack_r <= ack_nxt;
      dat_r <= dat_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

  a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o) else $error("ack held over two cycles");
  a_write_holds_busy: assert property (@(posedge clk_i) disable iff (rst_i)
    (busy && wb_we_i && wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("write acknowledged during copy");

  // ==========================================================
  // Crossings
  logic pix_rst;
  logic req_s;
  logic ack_tgl_r, ack_tgl_nxt;
  logic [DW+2:0] pin_s;
  logic field_r, field_nxt;
  logic vwin_r, vwin_nxt;

  sync2 #(.W(1)) u_rst (.clk_i(pix_clk_i), .rst_i(1'b0), .d_i(rst_i),
    .q_o(pix_rst));
  sync2 #(.W(1)) u_req (.clk_i(pix_clk_i), .rst_i(pix_rst),
    .d_i(req_tgl_r), .q_o(req_s));
  sync2 #(.W(1)) u_ack (.clk_i(clk_i), .rst_i(rst_i), .d_i(ack_tgl_r),
    .q_o(ack_tgl_s));
  sync2 #(.W(2)) u_stat (.clk_i(clk_i), .rst_i(rst_i),
    .d_i({vwin_r, field_r}), .q_o(stat_s));
  sync2 #(.W(DW+3)) u_pin (.clk_i(pix_clk_i), .rst_i(pix_rst),
    .d_i({pix_data_i, field_id_i, frame_sync_i, line_sync_i}),
    .q_o(pin_s));

  // ==========================================================
  // Pixel side staged and active settings
  capture_pkg::sync_dir_t st_dir_r, st_dir_nxt, dir_a_r, dir_a_nxt;
  capture_pkg::set16_t st_plen_r, st_plen_nxt, st_hlpf_r, st_hlpf_nxt;
  capture_pkg::set16_t plen_a_r, plen_a_nxt, hlpf_a_r, hlpf_a_nxt;
  capture_pkg::set15_t st_spix_r, st_spix_nxt, st_npix_r, st_npix_nxt;
  capture_pkg::set15_t st_sl0_r, st_sl0_nxt, st_sl1_r, st_sl1_nxt;
  capture_pkg::set15_t st_nlin_r, st_nlin_nxt;
  capture_pkg::set15_t spix_a_r, spix_a_nxt, npix_a_r, npix_a_nxt;
  capture_pkg::set15_t sl0_a_r, sl0_a_nxt, sl1_a_r, sl1_a_nxt;
  capture_pkg::set15_t nlin_a_r, nlin_a_nxt;
  logic [15:0] h_r, h_nxt, hl_r, hl_nxt, px_r, px_nxt, ln_r, ln_nxt;
  logic [15:0] wcnt_r, wcnt_nxt;
  logic line_p_r, line_p_nxt, frame_p_r, frame_p_nxt;
  logic ls_o_nxt, fs_o_nxt, oe_nxt, wr_nxt;
  logic [DW-1:0] md_nxt;
  logic ls_evt, fs_evt, gen, hwin, vwin;
  logic [15:0] pos, hcount, sl;

  assign gen = dir_a_r == capture_pkg::SYNC_OUT;

  always_comb begin
    logic half_tick;
    half_tick = 1'b0;
    st_dir_nxt = st_dir_r;
    st_plen_nxt = st_plen_r;
    st_hlpf_nxt = st_hlpf_r;
    st_spix_nxt = st_spix_r;
    st_npix_nxt = st_npix_r;
    st_sl0_nxt = st_sl0_r;
    st_sl1_nxt = st_sl1_r;
    st_nlin_nxt = st_nlin_r;
    ack_tgl_nxt = ack_tgl_r;
    // System registers are stable while the toggles differ
    if (req_s != ack_tgl_r) begin
      st_dir_nxt = capture_pkg::sync_dir_t'(dir_r);
      st_plen_nxt = plen_r;
      st_hlpf_nxt = hlpf_r;
      st_spix_nxt = spix_r;
      st_npix_nxt = npix_r;
      st_sl0_nxt = sl0_r;
      st_sl1_nxt = sl1_r;
      st_nlin_nxt = nlin_r;
      ack_tgl_nxt = req_s;
    end
    line_p_nxt = pin_s[0];
    frame_p_nxt = pin_s[1];
    h_nxt = (h_r >= plen_a_r) ? 16'h0000 : h_r + 16'h0001;
    half_tick = (h_r == 16'h0000) || (h_r == {1'b0, plen_a_r[15:1]});
    fs_evt = gen ? (half_tick && hl_r >= hlpf_a_r) : (pin_s[1] && !frame_p_r);
    hl_nxt = hl_r;
    if (fs_evt) begin
      hl_nxt = 16'h0000;
    end else if (half_tick) begin
      hl_nxt = hl_r + 16'h0001;
    end
    // input mode ignores the generated period
    if (!gen) begin
      h_nxt = 16'h0000;
      hl_nxt = 16'h0000;
    end
    ls_evt = gen ? (h_r == 16'h0000) : (pin_s[0] && !line_p_r);
    oe_nxt = st_dir_r == capture_pkg::SYNC_OUT;
    ls_o_nxt = gen && ls_evt;
    fs_o_nxt = gen && fs_evt;
    // settings other than direction take effect at frame sync; direction follows the staged value at once
    dir_a_nxt = st_dir_r;
    plen_a_nxt = fs_evt ? st_plen_r : plen_a_r;
    hlpf_a_nxt = fs_evt ? st_hlpf_r : hlpf_a_r;
    spix_a_nxt = fs_evt ? st_spix_r : spix_a_r;
    npix_a_nxt = fs_evt ? st_npix_r : npix_a_r;
    sl0_a_nxt = fs_evt ? st_sl0_r : sl0_a_r;
    sl1_a_nxt = fs_evt ? st_sl1_r : sl1_a_r;
    nlin_a_nxt = fs_evt ? st_nlin_r : nlin_a_r;
    pos = ls_evt ? 16'h0000 : px_r;
    px_nxt = (pos == 16'hffff) ? pos : pos + 16'h0001;
    ln_nxt = ln_r;
    if (fs_evt) begin
      ln_nxt = 16'h0000;
    end else if (ls_evt && ln_r != 16'hffff) begin
      ln_nxt = ln_r + 16'h0001;
    end
    field_nxt = fs_evt ? pin_s[2] : field_r;
    sl = {1'b0, sl0_a_r};
    if (field_r) begin
      sl = {1'b0, sl1_a_r};
    end
    vwin = (ln_r >= sl) && ((ln_r - sl) <= {1'b0, nlin_a_r});
    hcount = ({1'b0, npix_a_r} + 16'h0001) & `PIX_ROUND_MASK;
    hwin = (pos >= {1'b0, spix_a_r}) &&
      ((pos - {1'b0, spix_a_r}) < hcount);
    vwin_nxt = vwin;
    wr_nxt = vwin && hwin && !fs_evt;
    md_nxt = pin_s[DW+2:3];
    wcnt_nxt = ls_evt ? {15'h0, wr_nxt} : wcnt_r + {15'h0, wr_nxt};
  end

  always_ff @(posedge pix_clk_i) begin
    if (pix_rst) begin
      st_dir_r <= capture_pkg::SYNC_IN;
      st_plen_r <= `REG_RESET;
      st_hlpf_r <= `REG_RESET;
      st_spix_r <= 15'h0000;
      st_npix_r <= 15'h0000;
      st_sl0_r <= 15'h0000;
      st_sl1_r <= 15'h0000;
      st_nlin_r <= 15'h0000;
      dir_a_r <= capture_pkg::SYNC_IN;
      plen_a_r <= `REG_RESET;
      hlpf_a_r <= `REG_RESET;
      spix_a_r <= 15'h0000;
      npix_a_r <= 15'h0000;
      sl0_a_r <= 15'h0000;
      sl1_a_r <= 15'h0000;
      nlin_a_r <= 15'h0000;
      ack_tgl_r <= 1'b0;
      h_r <= 16'h0000;
      hl_r <= 16'h0000;
      px_r <= 16'h0000;
      ln_r <= 16'hffff;
      wcnt_r <= 16'h0000;
      line_p_r <= 1'b0;
      frame_p_r <= 1'b0;
      field_r <= 1'b0;
      vwin_r <= 1'b0;
      line_sync_o <= 1'b0;
      frame_sync_o <= 1'b0;
      line_sync_oe_o <= 1'b0;
      frame_sync_oe_o <= 1'b0;
      mem_wr_o <= 1'b0;
      mem_data_o <= '0;
    end else begin
      st_dir_r <= st_dir_nxt;
      st_plen_r <= st_plen_nxt;
      st_hlpf_r <= st_hlpf_nxt;
      st_spix_r <= st_spix_nxt;
      st_npix_r <= st_npix_nxt;
      st_sl0_r <= st_sl0_nxt;
      st_sl1_r <= st_sl1_nxt;
      st_nlin_r <= st_nlin_nxt;
      dir_a_r <= dir_a_nxt;
      plen_a_r <= plen_a_nxt;
      hlpf_a_r <= hlpf_a_nxt;
      spix_a_r <= spix_a_nxt;
      npix_a_r <= npix_a_nxt;
      sl0_a_r <= sl0_a_nxt;
      sl1_a_r <= sl1_a_nxt;
      nlin_a_r <= nlin_a_nxt;
      ack_tgl_r <= ack_tgl_nxt;
      h_r <= h_nxt;
      hl_r <= hl_nxt;
      px_r <= px_nxt;
      ln_r <= ln_nxt;
      wcnt_r <= wcnt_nxt;
      line_p_r <= line_p_nxt;
      frame_p_r <= frame_p_nxt;
      field_r <= field_nxt;
      vwin_r <= vwin_nxt;
      line_sync_o <= ls_o_nxt;
      frame_sync_o <= fs_o_nxt;
      line_sync_oe_o <= oe_nxt;
      frame_sync_oe_o <= oe_nxt;
      mem_wr_o <= wr_nxt;
      mem_data_o <= md_nxt;
    end
  end

  // ==========================================================
  // Checks on the pixel side
  a_half_line_range: assert property (@(posedge pix_clk_i)
    disable iff (pix_rst) gen |-> hl_r <= hlpf_a_r)
    else $error("half line count passed the frame period");
  a_input_ignores: assert property (@(posedge pix_clk_i)
    disable iff (pix_rst) !gen |=> hl_r == 16'h0000)
    else $error("half line counter ran in input mode");
  a_shadow_at_sync: assert property (@(posedge pix_clk_i)
    disable iff (pix_rst)
    ($changed(spix_a_r) || $changed(nlin_a_r)) |-> $past(fs_evt))
    else $error("window setting changed outside frame sync");
  a_start_pixel: assert property (@(posedge pix_clk_i)
    disable iff (pix_rst)
    mem_wr_o |-> $past(pos) >= {1'b0, $past(spix_a_r)})
    else $error("pixel written before start pixel");
  a_pixel_count: assert property (@(posedge pix_clk_i)
    disable iff (pix_rst)
    wcnt_r <= (({1'b0, npix_a_r} + 16'h0001) & `PIX_ROUND_MASK))
    else $error("too many pixels written in a line");
  a_start_line: assert property (@(posedge pix_clk_i)
    disable iff (pix_rst) mem_wr_o |-> $past(ln_r) >= $past(sl))
    else $error("line written before start line");
  a_line_count: assert property (@(posedge pix_clk_i)
    disable iff (pix_rst)
    mem_wr_o |-> ($past(ln_r) - $past(sl)) <= {1'b0, $past(nlin_a_r)})
    else $error("line written past line count");
  a_sync_in_mode: assert property (@(posedge pix_clk_i)
    disable iff (pix_rst)
    st_dir_r == capture_pkg::SYNC_IN |=> !line_sync_oe_o)
    else $error("sync driven while configured as input");
  a_line_wrap: assert property (@(posedge pix_clk_i)
    disable iff (pix_rst)
    (gen && h_r >= plen_a_r && !fs_evt) |=> h_r == 16'h0000)
    else $error("line counter did not wrap at period end");
  a_counter_restart: assert property (@(posedge pix_clk_i)
    disable iff (pix_rst) ls_evt |=> px_r == 16'h0001)
    else $error("pixel counter not restarted at line sync");

endmodule // capture_window
`default_nettype wire

// ==== capture_cfg.svh ====
// Constants for the sensor frame capture window block
// Function
// - Generated frame sync period counts half lines: (half_lines_per_frame+1)/2 lines.
// - Half-lines-per-frame setting ignored while syncs are inputs.
// - Period and window settings take effect only at the frame sync.
// - Pixel writes start at start-pixel position counted from line sync start.
// - Pixels written per line are (pixel count + 1) rounded down to 16.
// - Field 0 line writes start at field-0 start line from frame sync.
// - Field 1 line writes start at field-1 start line from frame sync.
// - Exactly line count + 1 lines are written per frame or field.
// - Sync direction control: 0 syncs are inputs, 1 device drives them.
// - Generated line period lasts pixels-per-line + 1 pixel clocks.
`ifndef CAPTURE_CFG_SVH
`define CAPTURE_CFG_SVH

`define OFS_MODE 8'h00
`define OFS_PLEN 8'h04
`define OFS_HLPF 8'h08
`define OFS_SPIX 8'h0c
`define OFS_NPIX 8'h10
`define OFS_SL0 8'h14
`define OFS_SL1 8'h18
`define OFS_NLIN 8'h1c
`define OFS_STAT 8'h20

`define MODE_DIR_BIT 0
`define STAT_FIELD_BIT 0
`define STAT_VWIN_BIT 1

`define W16 16
`define W15 15
`define REG_RESET 16'h0000
`define PIX_ROUND_MASK 16'hfff0

`endif

// ==== capture_pkg.sv ====
// Types shared by the sensor frame capture window block
`default_nettype none
package capture_pkg;

  typedef enum logic [0:0] {
    SYNC_IN = 1'b0,
    SYNC_OUT = 1'b1
  } sync_dir_t;

  typedef logic [15:0] set16_t;
  typedef logic [14:0] set15_t;

endpackage
`default_nettype wire

// ==== sync2.sv ====
// Two flip-flop synchroniser for levels and toggles
`default_nettype none
module sync2 #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] q_nxt;

  always_comb begin
    meta_nxt = d_i;
    q_nxt = meta_r;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_r <= '0;
      q_o <= '0;
    end else begin
      meta_r <= meta_nxt;
      q_o <= q_nxt;
    end
  end
endmodule // sync2
`default_nettype wire

// ==== sensor_model.sv ====
// Sensor model driving pixel data, line and frame syncs and field id
`default_nettype none
module sensor_model #(
  parameter int LINE = 60,
  parameter int LINES = 8
) (
  input wire logic pix_clk_i,
  input wire logic rst_i,
  output logic [15:0] data_o,
  output logic line_sync_o,
  output logic frame_sync_o,
  output logic field_o
);
  timeunit 1ns;
  timeprecision 100ps;
  int h;
  int l;
  // ==========================================
  // Raster counters
  // field per frame
  always @(posedge pix_clk_i) begin
    if (rst_i) begin
      h <= 0;
      l <= 0;
      field_o <= 1'b0;
    end else begin
      h <= (h == LINE - 1) ? 0 : h + 1;
      if (h == LINE - 1) begin
        l <= (l == LINES - 1) ? 0 : l + 1;
        if (l == LINES - 1) field_o <= ~field_o;
      end
    end
  end
  // Data carries line and position so every cycle differs
  assign data_o = {l[7:0], h[7:0]};
  assign line_sync_o = (h == 0) && !rst_i;
  assign frame_sync_o = (h == 0) && (l == 0) && !rst_i;
endmodule // sensor_model
`default_nettype wire

// ==== capture_window_test.sv ====
// Self-checking bench for the capture window block
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin failures++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); end end
module capture_window_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i = 0, rst_i = 1, pix_clk = 0;
  logic cyc = 0, stb = 0, we = 0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0, rd;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, ls_o, ls_oe, fs_o, fs_oe, mem_wr_o, m_ls, m_fs, fld_i;
  logic line_sync_i, frame_sync_i;
  logic [15:0] pix_d, mem_data_o;
  int failures = 0, checks_done = 0;
  int fr = 0, lcnt = 0, lper = 0, fcnt = 0, fper = 0, gf = 0;
  int wc[8] = '{default: 0};
  logic [15:0] fd[8], ld[8];
  logic fl[8];
  logic fs_q = 0;
  logic [7:0] sl;
  initial forever #5 clk_i = ~clk_i;
  initial begin
    #3;
    forever #7.5 pix_clk = ~pix_clk;
  end
  // ==========================================
  // Sync wires: device drives while enabled
  assign line_sync_i = ls_oe ? ls_o : m_ls;
  assign frame_sync_i = fs_oe ? fs_o : m_fs;
  sensor_model SNS (.pix_clk_i(pix_clk), .rst_i(rst_i), .data_o(pix_d),
    .line_sync_o(m_ls), .frame_sync_o(m_fs), .field_o(fld_i));
  capture_window DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .pix_clk_i(pix_clk), .pix_data_i(pix_d), .line_sync_i(line_sync_i),
    .frame_sync_i(frame_sync_i), .field_id_i(fld_i), .line_sync_o(ls_o),
    .line_sync_oe_o(ls_oe), .frame_sync_o(fs_o), .frame_sync_oe_o(fs_oe),
    .mem_wr_o(mem_wr_o), .mem_data_o(mem_data_o));
  // ==========================================
  // Pixel side monitor: per frame writes, sync periods
  always @(posedge pix_clk) begin
    fs_q <= frame_sync_i;
    if (frame_sync_i && !fs_q && fr < 7) begin
      fr <= fr + 1;
      fl[fr + 1] <= fld_i;
    end
    if (mem_wr_o === 1'b1) begin
      if (wc[fr] == 0) fd[fr] <= mem_data_o;
      ld[fr] <= mem_data_o;
      wc[fr] <= wc[fr] + 1;
    end
    lcnt <= (ls_o === 1'b1) ? 1 : lcnt + 1;
    if (ls_o === 1'b1) lper <= lcnt;
    fcnt <= (fs_o === 1'b1) ? 1 : fcnt + 1;
    if (fs_o === 1'b1) begin
      fper <= fcnt;
      gf <= gf + 1;
    end
  end
  task automatic results();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= s;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 100);
    rd = wb_dat_o;
    cyc <= 0;
    stb <= 0;
    we <= 0;
    if (n >= 100) begin
      failures++;
      results();
    end
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, 4'hf);
    `CHK(rd, e)
  endtask
  task automatic wait_until(ref int v, input int k);
    int n;
    for (n = 0; n < 20000 && v < k; n++) @(posedge clk_i);
    if (v < k) begin
      failures++;
      results();
    end
  endtask
  task automatic chk_frame(input int f, input logic [7:0] sp);
    sl = fl[f] ? 8'h03 : 8'h02;
    `CHK(wc[f], 64)
    `CHK(fd[f], {sl, sp})
    `CHK(ld[f], {sl + 8'h01, sp + 8'h1f})
  endtask
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 0;
    for (int a = 0; a < 9; a++) chk_rd(8'(a * 4), 32'h0);
    chk_rd(8'h24, 32'h0);
    bus(1'b1, 8'h0c, 32'h00007fff, 4'h1);
    chk_rd(8'h0c, 32'h000000ff);
    bus(1'b1, 8'h0c, 32'h00007fff, 4'hf);
    chk_rd(8'h0c, 32'h00007fff);
    bus(1'b1, 8'h08, 32'h0000ffff, 4'hf);
    chk_rd(8'h08, 32'h0000ffff);
    bus(1'b1, 8'h24, 32'h12345678, 4'hf);
    chk_rd(8'h24, 32'h0);
    $display("test registers done");
    wait_until(fr, 1);
    bus(1'b1, 8'h0c, 32'h4, 4'hf);
    bus(1'b1, 8'h10, 32'h22, 4'hf);
    bus(1'b1, 8'h14, 32'h2, 4'hf);
    bus(1'b1, 8'h18, 32'h3, 4'hf);
    bus(1'b1, 8'h1c, 32'h1, 4'hf);
    bus(1'b1, 8'h08, 32'h7, 4'hf);
    wait_until(fr, 2);
    bus(1'b1, 8'h0c, 32'h8, 4'hf);
    wait_until(fr, 4);
    chk_frame(2, 8'h04);
    chk_frame(3, 8'h08);
    `CHK(fl[2] ^ fl[3], 1'b1)
    `CHK(wc[1], 0)
    `CHK(fs_oe, 1'b0)
    `CHK(ls_oe, 1'b0)
    $display("test input capture done");
    bus(1'b1, 8'h04, 32'h13, 4'hf);
    bus(1'b1, 8'h08, 32'h7, 4'hf);
    bus(1'b1, 8'h00, 32'h1, 4'hf);
    wait_until(gf, 4);
    `CHK(lper, 20)
    `CHK(fper, 80)
    `CHK(ls_oe, 1'b1)
    `CHK(fs_oe, 1'b1)
    $display("test generated syncs done");
    results();
  end
endmodule // capture_window_test
`default_nettype wire
